/* logic/pvic_top.sv */
// interrupt controller top: sources, masking, arbitration, wishbone registers
//
// Contract
// - fast core request only from fast pin
// - standard request from peripherals and four pins
// - eight-level priority encoder ranks standard sources
// - per-source mask and vector naming serviced source
// - internal sources: level or edge detection
// - external sources: rise, fall, high, low
// - one line from each parallel io controller
// - one line from every timer channel
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pvic_top
    import pvic_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic EXT_FAST_IRQ_PIN,
    input wire logic [NUM_EXT-1:0] EXT_IRQ_PIN,
    input wire logic IO_CTRL_A_IRQ,
    input wire logic IO_CTRL_B_IRQ,
    input wire logic [NUM_TMR-1:0] TIMER_IRQ,
    output logic CORE_FAST_IRQ_IN_N,
    output logic CORE_STD_IRQ_IN_N,
    output logic [SRC_W-1:0] IRQ_VECTOR,
    output logic IRQ_ACTIVE
);
    // ------------------------------------------------------------------
    // source gathering
    // ------------------------------------------------------------------
    logic [NUM_SRC-1:0] src_in;
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] clr_src;
    logic [NUM_SRC*PRIO_W-1:0] prio_flat;
    logic [NUM_SRC*2-1:0] sense_eff;
    logic fast_pend;
    logic fast_clr;

    always_comb
    begin
        src_in = '0;
        src_in[SRC_IO_A] = IO_CTRL_A_IRQ;
        src_in[SRC_IO_B] = IO_CTRL_B_IRQ;
        src_in[SRC_TMR0 +: NUM_TMR] = TIMER_IRQ;
        src_in[SRC_EXT0 +: NUM_EXT] = EXT_IRQ_PIN;
    end

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [PRIO_W-1:0] prio_q [NUM_SRC];
    logic [PRIO_W-1:0] prio_d [NUM_SRC];
    logic [1:0] sense_q [NUM_SRC+1];
    logic [1:0] sense_d [NUM_SRC+1];
    logic [STAT_W-1:0] enable_q, enable_d;
    logic [31:0] dat_q, dat_d;
    logic ack_q, ack_d;
    logic fast_n_q, fast_n_d;
    logic std_n_q, std_n_d;
    logic [SRC_W-1:0] vec_q, vec_d;
    logic active_q, active_d;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : gen_src
            // internal lines only offer high level or rising edge
            if (g < SRC_EXT0)
            begin : gen_int
                assign sense_eff[g*2 +: 2] = {1'b1, sense_q[g][0]};
            end
            else
            begin : gen_ext
                assign sense_eff[g*2 +: 2] = sense_q[g];
            end
            assign prio_flat[g*PRIO_W +: PRIO_W] = prio_q[g];
            pvic_detect u_det (
                .clk(REF_CLK),
                .rst(RST),
                .src(src_in[g]),
                .sense(sense_eff[g*2 +: 2]),
                .clr(clr_src[g]),
                .pending(pend[g])
            );
        end
    endgenerate

    pvic_detect u_fast_det (
        .clk(REF_CLK),
        .rst(RST),
        .src(EXT_FAST_IRQ_PIN),
        .sense(sense_q[NUM_SRC]),
        .clr(fast_clr),
        .pending(fast_pend)
    );

    // ------------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------------
    logic [NUM_SRC-1:0] req_masked;
    logic win_valid;
    logic [SRC_W-1:0] win_index;
    logic [PRIO_W-1:0] win_level;
    logic [STAT_W-1:0] status;

    assign req_masked = pend & enable_q[NUM_SRC-1:0];
    assign status = {fast_pend, pend};

    pvic_prio u_prio (
        .req(req_masked),
        .prio(prio_flat),
        .valid(win_valid),
        .index(win_index),
        .level(win_level)
    );

    // ------------------------------------------------------------------
    // wishbone slave: one wait state, unmapped reads give zero
    // ------------------------------------------------------------------
    logic bus_req;
    logic wr;
    logic [31:0] wmask;
    logic [31:0] wdat;

    always_comb
    begin
        // ack_q in the term stops a held strobe from being taken twice
        bus_req = WB_CYC_I & WB_STB_I & ~ack_q;
        wr = bus_req & WB_WE_I;
        for (int b = 0; b < 4; b++)
        begin
            wmask[b*8 +: 8] = {8{WB_SEL_I[b]}};
        end
        wdat = WB_DAT_I & wmask;
        ack_d = bus_req;
        enable_d = enable_q;
        clr_src = '0;
        fast_clr = 1'b0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            prio_d[i] = prio_q[i];
            sense_d[i] = sense_q[i];
        end
        sense_d[NUM_SRC] = sense_q[NUM_SRC];
        if (wr)
        begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
                if (WB_ADR_I == OFS_MODE0 + ADR_W'(4 * i) && WB_SEL_I[0])
                begin
                    prio_d[i] = WB_DAT_I[MODE_PRIO_LSB +: PRIO_W];
                    sense_d[i] = WB_DAT_I[MODE_SENSE_LSB +: 2];
                end
            end
            if (WB_ADR_I == OFS_FAST_MODE && WB_SEL_I[0])
            begin
                sense_d[NUM_SRC] = WB_DAT_I[MODE_SENSE_LSB +: 2];
            end
            // set and clear addresses change single enables without a read
            case (WB_ADR_I)
                OFS_EN_SET: enable_d = enable_q | wdat[STAT_W-1:0];
                OFS_EN_CLR: enable_d = enable_q & ~wdat[STAT_W-1:0];
                OFS_CLEAR:
                begin
                    // acknowledge of edge sources; level sources ignore it
                    clr_src = wdat[NUM_SRC-1:0];
                    fast_clr = wdat[FAST_BIT];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read answer: decoded in the taking cycle, shown with ack
    // ------------------------------------------------------------------
    always_comb
    begin
        // zero outside a read answer keeps the data bus quiet between cycles
        dat_d = '0;
        if (bus_req && !WB_WE_I)
        begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
                if (WB_ADR_I == OFS_MODE0 + ADR_W'(4 * i))
                begin
                    dat_d[MODE_PRIO_LSB +: PRIO_W] = prio_q[i];
                    dat_d[MODE_SENSE_LSB +: 2] = sense_eff[i*2 +: 2];
                end
            end
            // mode addresses fall to the empty default and keep the value above
            case (WB_ADR_I)
                OFS_FAST_MODE: dat_d[MODE_SENSE_LSB +: 2] = sense_q[NUM_SRC];
                OFS_VECTOR:
                begin
                    // reading the vector does not acknowledge the source
                    dat_d[SRC_W-1:0] = win_index;
                    dat_d[VEC_LEVEL_LSB +: PRIO_W] = win_level;
                    dat_d[VEC_VALID_BIT] = win_valid;
                end
                // status shows enabled sources only; raw shows them all
                OFS_STATUS: dat_d[STAT_W-1:0] = status & enable_q;
                OFS_ENABLE: dat_d[STAT_W-1:0] = enable_q;
                OFS_RAW: dat_d[STAT_W-1:0] = status;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // core request outputs, registered so they never glitch
    // ------------------------------------------------------------------
    always_comb
    begin
        fast_n_d = ~(fast_pend & enable_q[FAST_BIT]);
        std_n_d = ~win_valid;
        vec_d = win_index;
        active_d = |(status & enable_q);
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        // the vector moves on the same edge as the request it belongs to
        if (RST)
        begin
            fast_n_q <= 1'b1;
            std_n_q <= 1'b1;
            vec_q <= NO_SOURCE;
            active_q <= 1'b0;
        end
        else
        begin
            fast_n_q <= fast_n_d;
            std_n_q <= std_n_d;
            vec_q <= vec_d;
            active_q <= active_d;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
                prio_q[i] <= PRIO_RST;
                sense_q[i] <= SENSE_RST;
            end
            // the fast line's sense sits one past the last source
            sense_q[NUM_SRC] <= SENSE_RST;
            enable_q <= ENABLE_RST;
        end
        else
        begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
                prio_q[i] <= prio_d[i];
                sense_q[i] <= sense_d[i];
            end
            sense_q[NUM_SRC] <= sense_d[NUM_SRC];
            enable_q <= enable_d;
        end
    end

    // ------------------------------------------------------------------
    // bus answer registers
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        // a registered ack costs one wait state but cannot glitch
        if (RST)
        begin
            dat_q <= '0;
            ack_q <= 1'b0;
        end
        else
        begin
            dat_q <= dat_d;
            ack_q <= ack_d;
        end
    end

    assign WB_DAT_O = dat_q;
    assign WB_ACK_O = ack_q;
    assign CORE_FAST_IRQ_IN_N = fast_n_q;
    assign CORE_STD_IRQ_IN_N = std_n_q;
    assign IRQ_VECTOR = vec_q;
    assign IRQ_ACTIVE = active_q;
endmodule
`default_nettype wire

/* logic/pvic_pkg.sv */
// shared constants for the prioritised vectored interrupt controller
package pvic_pkg;

    // ------------------------------------------------------------------
    // source numbering
    // ------------------------------------------------------------------
    localparam int NUM_SRC = 12;
    localparam int SRC_W = 4;
    localparam int SRC_IO_A = 0;
    localparam int SRC_IO_B = 1;
    localparam int SRC_TMR0 = 2;
    localparam int NUM_TMR = 6;
    localparam int SRC_EXT0 = 8;
    localparam int NUM_EXT = 4;
    localparam int PRIO_W = 3;
    localparam logic [SRC_W-1:0] NO_SOURCE = 4'hf;

    // ------------------------------------------------------------------
    // detection types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PVIC_LOW_LEVEL = 2'b00,
        PVIC_FALL_EDGE = 2'b01,
        PVIC_HIGH_LEVEL = 2'b10,
        PVIC_RISE_EDGE = 2'b11
    } pvic_sense_t;

    // ------------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] OFS_MODE0 = 8'h00;
    localparam logic [ADR_W-1:0] OFS_FAST_MODE = 8'h30;
    localparam logic [ADR_W-1:0] OFS_VECTOR = 8'h40;
    localparam logic [ADR_W-1:0] OFS_STATUS = 8'h44;
    localparam logic [ADR_W-1:0] OFS_ENABLE = 8'h48;
    localparam logic [ADR_W-1:0] OFS_EN_SET = 8'h4c;
    localparam logic [ADR_W-1:0] OFS_EN_CLR = 8'h50;
    localparam logic [ADR_W-1:0] OFS_CLEAR = 8'h54;
    localparam logic [ADR_W-1:0] OFS_RAW = 8'h58;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int MODE_PRIO_LSB = 0;
    localparam int MODE_SENSE_LSB = 5;
    localparam int VEC_LEVEL_LSB = 4;
    localparam int VEC_VALID_BIT = 8;
    localparam int FAST_BIT = 12;
    localparam int STAT_W = 13;
    localparam logic [STAT_W-1:0] ENABLE_RST = 13'h0000;
    localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
    localparam logic [1:0] SENSE_RST = 2'h2;

endpackage

/* logic/pvic_detect.sv */
// one source detector: level or edge sensing with a sticky edge latch
`timescale 1ns/1ps
`default_nettype none
module pvic_detect
    import pvic_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic src,
    input wire logic [1:0] sense,
    input wire logic clr,
    output logic pending
);
    logic src_q, src_d;
    logic latch_q, latch_d;
    logic edge_seen;

    always_comb
    begin
        src_d = src;
        unique case (pvic_sense_t'(sense))
            PVIC_RISE_EDGE: edge_seen = src & ~src_q;
            PVIC_FALL_EDGE: edge_seen = ~src & src_q;
            default: edge_seen = 1'b0;
        endcase
        // a new edge in the clearing cycle is kept
        latch_d = edge_seen | (latch_q & ~clr);
        if (!sense[0])
        begin
            latch_d = 1'b0;
        end
        case (pvic_sense_t'(sense))
            PVIC_HIGH_LEVEL: pending = src;
            PVIC_LOW_LEVEL: pending = ~src;
            default: pending = latch_q;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            src_q <= 1'b0;
            latch_q <= 1'b0;
        end
        else
        begin
            src_q <= src_d;
            latch_q <= latch_d;
        end
    end
endmodule
`default_nettype wire

/* logic/pvic_prio.sv */
// eight-level priority encoder; ties go to the lowest source number
`timescale 1ns/1ps
`default_nettype none
module pvic_prio
    import pvic_pkg::*;
(
    input wire logic [NUM_SRC-1:0] req,
    input wire logic [NUM_SRC*PRIO_W-1:0] prio,
    output logic valid,
    output logic [SRC_W-1:0] index,
    output logic [PRIO_W-1:0] level
);
    always_comb
    begin
        valid = 1'b0;
        index = NO_SOURCE;
        level = '0;
        // scan downward so equal levels settle on the lowest number
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (req[i] && (!valid || prio[i*PRIO_W +: PRIO_W] >= level))
            begin
                valid = 1'b1;
                index = SRC_W'(i);
                level = prio[i*PRIO_W +: PRIO_W];
            end
        end
    end
endmodule
`default_nettype wire

/* tb/pvic_sva.sv */
// port-level assertion checker for the interrupt controller top
`timescale 1ns/1ps
`default_nettype none
module pvic_sva
    import pvic_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic EXT_FAST_IRQ_PIN,
    input wire logic [NUM_EXT-1:0] EXT_IRQ_PIN,
    input wire logic IO_CTRL_A_IRQ,
    input wire logic IO_CTRL_B_IRQ,
    input wire logic [NUM_TMR-1:0] TIMER_IRQ,
    input wire logic CORE_FAST_IRQ_IN_N,
    input wire logic CORE_STD_IRQ_IN_N,
    input wire logic [SRC_W-1:0] IRQ_VECTOR,
    input wire logic IRQ_ACTIVE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    sequence req_taken;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence ack_pulse;
        WB_ACK_O ##1 !WB_ACK_O;
    endsequence
    // three quiet cycles just cover the two-edge source latency, with none to spare
    sequence src_quiet;
        !WB_CYC_I && !WB_ACK_O
            && $stable({EXT_IRQ_PIN, IO_CTRL_A_IRQ, IO_CTRL_B_IRQ, TIMER_IRQ});
    endsequence
    sequence fast_quiet;
        !WB_CYC_I && !WB_ACK_O && $stable(EXT_FAST_IRQ_PIN);
    endsequence
    chk_ack_one_wait: assert property (req_taken |=> ack_pulse)
        else $error("ack not one cycle after request");
    chk_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    chk_rdata_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data outside answer");
    chk_std_active: assert property (!CORE_STD_IRQ_IN_N |-> IRQ_ACTIVE)
        else $error("standard request without active flag");
    chk_fast_active: assert property (!CORE_FAST_IRQ_IN_N |-> IRQ_ACTIVE)
        else $error("fast request without active flag");
    chk_vec_none: assert property (CORE_STD_IRQ_IN_N == (IRQ_VECTOR == NO_SOURCE))
        else $error("vector and standard request disagree");
    chk_fast_alone: assert property (fast_quiet [*3] |-> $stable(CORE_FAST_IRQ_IN_N))
        else $error("fast request moved without fast pin");
    chk_std_hold: assert property (src_quiet [*3] |-> $stable({IRQ_VECTOR, CORE_STD_IRQ_IN_N}))
        else $error("standard request moved without cause");
endmodule
bind pvic_top pvic_sva u_sva (.*);
`default_nettype wire

/* tb/pvic_src_model.sv */
// far-side model: peripheral and pin interrupt lines
`timescale 1ns/1ps
`default_nettype none
module pvic_src_model
    import pvic_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [NUM_SRC-1:0] want,
    input wire logic want_fast,
    output logic io_a,
    output logic io_b,
    output logic [NUM_TMR-1:0] tmr,
    output logic [NUM_EXT-1:0] ext,
    output logic fast
);
    // lines leave peripheral flops, so they only move after an edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {ext, tmr, io_b, io_a} <= '0;
            fast <= 1'b0;
        end
        else
        begin
            {ext, tmr, io_b, io_a} <= want;
            fast <= want_fast;
        end
    end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pvic_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic want_fast = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [NUM_SRC-1:0] want = '0;
    logic [31:0] rdat;
    logic ack, fast_n, std_n, act, io_a, io_b, fpin;
    logic [SRC_W-1:0] vec;
    logic [NUM_TMR-1:0] tmr;
    logic [NUM_EXT-1:0] ext;
    logic [31:0] exp_q[$];
    logic [2:0] pr[3];
    logic [NUM_SRC-1:0] en;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int w;

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    pvic_src_model model (.clk(clk), .rst(rst), .want(want), .want_fast(want_fast),
        .io_a(io_a), .io_b(io_b), .tmr(tmr), .ext(ext), .fast(fpin));
    pvic_top uut (.REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .EXT_FAST_IRQ_PIN(fpin), .EXT_IRQ_PIN(ext), .IO_CTRL_A_IRQ(io_a),
        .IO_CTRL_B_IRQ(io_b), .TIMER_IRQ(tmr), .CORE_FAST_IRQ_IN_N(fast_n),
        .CORE_STD_IRQ_IN_N(std_n), .IRQ_VECTOR(vec), .IRQ_ACTIVE(act));

    // ------
    // checking and bus tasks
    // ------
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [6:0] exp);
        comparisons++;
        if ({act, fast_n, std_n, vec} !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: lines %h, expected %h", $time,
                {act, fast_n, std_n, vec}, exp);
        end
    endtask

    // lines move two edges after a cause; bounded wait, then compare
    task automatic wait_pin(input logic [6:0] exp);
        @(negedge clk);
        for (int n = 0; n < 12 && {act, fast_n, std_n, vec} !== exp; n++)
            @(negedge clk);
        chk_pin(exp);
    endtask

    // iff sees ack before this edge's updates land: the edge that samples it
    task automatic bus(input logic wr, input logic [ADR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= d;
        @(posedge clk iff ack);
        cyc <= 1'b0;
    endtask

    task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    always @(posedge clk)
    begin
        if (ack && !we && exp_q.size() > 0)
            chk_data(rdat, exp_q.pop_front());
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    // active level equals sense bit 1 for all four detection types
    task automatic run_src(input int i, input logic [1:0] s);
        @(posedge clk);
        want <= (want & ~(12'h1 << i)) | ({11'h0, ~s[1]} << i);
        bus(1'b1, OFS_MODE0 + 8'(4 * i), 32'({s, 5'h01}));
        bus(1'b1, OFS_CLEAR, 32'h1 << i);
        bus(1'b1, OFS_EN_SET, 32'h1 << i);
        wait_pin(7'h3f);
        @(posedge clk);
        want <= (want & ~(12'h1 << i)) | ({11'h0, s[1]} << i);
        wait_pin({3'b110, 4'(i)});
        @(posedge clk);
        want <= (want & ~(12'h1 << i)) | ({11'h0, ~s[1]} << i);
        if (s[0])
        begin
            repeat (6) @(negedge clk);
            chk_pin({3'b110, 4'(i)});
            bus(1'b1, OFS_CLEAR, 32'h1 << i);
        end
        wait_pin(7'h3f);
        bus(1'b1, OFS_EN_CLR, 32'h1 << i);
    endtask

    // ------
    // main sequence
    // ------
    initial
    begin
        void'($urandom(32'hfedc));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_MODE0, 32'h40);
        rd(OFS_FAST_MODE, 32'h40);
        bus(1'b1, OFS_ENABLE, 32'hfff);
        rd(OFS_ENABLE, 32'h0);
        rd(8'h5c, 32'h0);
        wait_pin(7'h3f);
        // random priorities on three timer lines, winners masked one by one
        for (int r = 0; r < 4; r++)
        begin
            for (int k = 0; k < 3; k++)
            begin
                pr[k] = 3'($urandom % 8);
                bus(1'b1, OFS_MODE0 + 8'(8 + 4 * k), 32'h40 | 32'(pr[k]));
            end
            en = 12'h01c;
            bus(1'b1, OFS_EN_SET, 32'(en));
            @(posedge clk);
            want <= 12'h01c;
            for (int m = 0; m < 3; m++)
            begin
                w = -1;
                for (int k = 0; k < 3; k++)
                    if (en[k + 2] && (w < 0 || pr[k] > pr[w]))
                        w = k;
                wait_pin({3'b110, 4'(w + 2)});
                rd(OFS_VECTOR, {24'h1, 1'b0, pr[w], 4'(w + 2)});
                rd(OFS_STATUS, 32'(en));
                en[w + 2] = 1'b0;
                bus(1'b1, OFS_EN_CLR, 32'h1 << (w + 2));
            end
            rd(OFS_RAW, 32'h01c);
            wait_pin(7'h3f);
        end
        @(posedge clk);
        want <= '0;
        for (int i = 0; i < NUM_SRC; i++)
            for (int s = 0; s < 4; s++)
                if (i >= SRC_EXT0 || s >= 2)
                    run_src(i, 2'(s));
        bus(1'b1, OFS_EN_SET, 32'h1 << FAST_BIT);
        @(posedge clk);
        want_fast <= 1'b1;
        wait_pin({3'b101, NO_SOURCE});
        rd(OFS_STATUS, 32'h1000);
        @(posedge clk);
        want_fast <= 1'b0;
        wait_pin(7'h3f);
        // fast line on rising edge: stays until cleared through bit 12
        bus(1'b1, OFS_FAST_MODE, 32'h60);
        @(posedge clk);
        want_fast <= 1'b1;
        wait_pin({3'b101, NO_SOURCE});
        @(posedge clk);
        want_fast <= 1'b0;
        repeat (4) @(negedge clk);
        chk_pin({3'b101, NO_SOURCE});
        bus(1'b1, OFS_CLEAR, 32'h1 << FAST_BIT);
        wait_pin(7'h3f);
        wrap_up();
    end
endmodule
`default_nettype wire
